// File: hw/vrs_pkg.sv
// Constants and types shared by the vector register set
package vrs_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned ELEM_BITS = 64;
  localparam int unsigned ELEMS     = 128;
  localparam int unsigned ACC_BASE  = 8;
  localparam int unsigned ACC_WIDE  = 16;
  localparam logic [7:0]  MAX_COUNT = 8'h80;

  // ----------------------------------------------------------------
  // Register word indices, byte offset in each comment (AHB-Lite, one word each)
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_COUNT  = 3'h0;  // 0x00
  localparam logic [2:0] REG_STRIDE = 3'h1;  // 0x04
  localparam logic [2:0] REG_FIRST  = 3'h2;  // 0x08
  localparam logic [2:0] REG_STATUS = 3'h3;  // 0x0c
  localparam logic [2:0] REG_MASK0  = 3'h4;  // 0x10..0x1c, low word first
  localparam int unsigned ST_BUSY   = 0;     // Status bit positions
  localparam int unsigned ST_WIDE   = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]   RST_COUNT  = 8'h00;
  localparam logic [31:0]  RST_STRIDE = 32'h0000_0000;
  localparam logic [6:0]   RST_FIRST  = 7'h00;
  localparam logic [127:0] RST_MASK   = 128'h0;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic {ST_IDLE, ST_RUN} vrs_state_e;
  typedef enum logic [3:0] {
    OP_COPY, OP_MERGE, OP_FILL, OP_CMP, OP_LOAD, OP_STORE,
    OP_COMPRESS, OP_EXPAND, OP_TO_ELEM, OP_TO_SCALAR
  } vrs_op_e;
  typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD, SZ_LONG} vrs_size_e;
  typedef enum logic [1:0] {CMP_EQ, CMP_NE, CMP_LT, CMP_LE} vrs_cmp_e;

  // ----------------------------------------------------------------
  // Whole state of the block apart from the accumulators
  // ----------------------------------------------------------------
  typedef struct packed {
    vrs_state_e   state;
    vrs_op_e      kind;
    logic [7:0]   count;
    logic [31:0]  stride;
    logic [6:0]   first;
    logic [127:0] mask;
    logic [4:0]   dsel;
    logic [4:0]   s1sel;
    logic [4:0]   s2sel;
    vrs_size_e    size;
    vrs_cmp_e     cmp;
    logic         masked;
    logic [63:0]  scalar;
    logic [7:0]   idx;
    logic [7:0]   lim;
    logic [6:0]   widx;
    logic [31:0]  addr;
    logic         done;
    logic [63:0]  result;
    logic         wpend;
    logic [2:0]   wreg;
    logic [31:0]  rdata;
  } vrs_regs_s;

endpackage

// File: hw/vrs_vector_register_set.sv
// Vector register set: accumulators, element count, stride, mask, first-element offset
//
// Summary of operation
// - Base variant has eight accumulators of 128 elements, 64 bits each.
// - Narrow writes into an element keep the element's upper bits.
// - Elements are numbered from zero.
// - Wide variant has sixteen accumulators of 128 by 64-bit elements.
// - Element count holds 0 to 128 and sets how many elements an operation handles.
// - Writing a negative element count stores zero.
// - Writing an element count above 128 stores 128.
// - With element count zero no element, mask bit or memory word is written.
// - Positive stride: element i sits at base plus i times stride.
// - Negative stride: element i sits at base minus i times stride magnitude.
// - Zero stride: every element uses the same memory operand.
// - Mask is 128 bits, one per element position.
// - Compare sets mask bits for true results and clears them for false.
// - Mask steers compress, expand, merge, masked ops; no masked ops in base.
// - Outside single-element moves, offset applies to an operand only when its select field bit 4 is set.
// - Offset never applies to the mask.
// - First-element offset is seven bits, 0 to 127.
// - When an operand takes the offset and offset plus count exceeds 128, only 128 minus offset elements run.
// - Single-element moves select element (offset plus scalar index) modulo 128.
`timescale 1ns/1ns
module vrs_vector_register_set #(
  parameter bit WIDE = 1'b1
) (
  input  wire logic           hclk,
  input  wire logic           hresetn,
  input  wire logic           hsel,
  input  wire logic [31:0]    haddr,
  input  wire logic [1:0]     htrans,
  input  wire logic           hwrite,
  input  wire logic [2:0]     hsize,
  input  wire logic [31:0]    hwdata,
  input  wire logic           hready,
  output logic                hreadyout,
  output logic                hresp,
  output logic [31:0]         hrdata,
  input  wire logic           op_start,
  output logic                op_ready,
  input  wire vrs_pkg::vrs_op_e   op_kind,
  input  wire vrs_pkg::vrs_size_e op_size,
  input  wire vrs_pkg::vrs_cmp_e  op_cmp,
  input  wire logic           op_masked,
  input  wire logic [4:0]     destination_operand,
  input  wire logic [4:0]     first_source_operand,
  input  wire logic [4:0]     second_source_operand,
  input  wire logic [6:0]     scalar_index_operand,
  input  wire logic [63:0]    op_scalar,
  input  wire logic [31:0]    op_base,
  output logic                op_done,
  output logic [63:0]         op_result,
  output logic                mem_req,
  output logic                mem_we,
  output logic [31:0]         mem_addr,
  output logic [63:0]         mem_wdata,
  output vrs_pkg::vrs_size_e  mem_size,
  input  wire logic           mem_ready,
  input  wire logic [63:0]    mem_rdata
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Narrow data lands in the low bits; bits above stay as they were
  function automatic logic [63:0] merge_width(input logic [63:0] old_v,
                                               input logic [63:0] new_v,
                                               input vrs_pkg::vrs_size_e sz);
    unique case (sz)
      vrs_pkg::SZ_BYTE: merge_width = {old_v[63:8], new_v[7:0]};
      vrs_pkg::SZ_HALF: merge_width = {old_v[63:16], new_v[15:0]};
      vrs_pkg::SZ_WORD: merge_width = {old_v[63:32], new_v[31:0]};
      vrs_pkg::SZ_LONG: merge_width = new_v;
    endcase
  endfunction

  // Flat array address of element e of the accumulator named by sel
  function automatic logic [10:0] elem_addr(input logic [4:0] sel,
                                            input logic [6:0] e,
                                            input logic [6:0] off);
    logic [3:0] acc;
    logic [6:0] pos;
    acc = WIDE ? sel[3:0] : {1'b0, sel[2:0]};
    pos = sel[4] ? 7'(off + e) : e;
    elem_addr = {acc, pos};
  endfunction

  function automatic logic compare(input logic [63:0] a,
                                   input logic [63:0] b,
                                   input vrs_pkg::vrs_cmp_e c);
    unique case (c)
      vrs_pkg::CMP_EQ: compare = (a == b);
      vrs_pkg::CMP_NE: compare = (a != b);
      vrs_pkg::CMP_LT: compare = ($signed(a) < $signed(b));
      vrs_pkg::CMP_LE: compare = ($signed(a) <= $signed(b));
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Accumulators: sixteen banks always present, upper eight unused in base variant
  logic [63:0] acc_mem [0:2047];

  vrs_pkg::vrs_regs_s s;
  vrs_pkg::vrs_regs_s next_s;

  logic        acc_we;
  logic [10:0] acc_waddr;
  logic [63:0] acc_wdata;
  logic [63:0] rd_a;
  logic [63:0] rd_b;
  logic [63:0] rd_d;
  logic [6:0]  ridx;
  logic        addr_ph;
  logic        step;
  logic        mbit;
  logic        use_off;
  logic [7:0]  off_sum;
  logic [6:0]  mov_pos;

  // ----------------------------------------------------------------
  // Element read ports
  // ----------------------------------------------------------------
  // Expand walks the source only on selected positions
  assign ridx = (s.kind == vrs_pkg::OP_EXPAND) ? s.widx : s.idx[6:0];
  assign rd_a = acc_mem[elem_addr(s.s1sel, ridx, s.first)];
  assign rd_b = acc_mem[elem_addr(s.s2sel, s.idx[6:0], s.first)];
  assign rd_d = acc_mem[acc_waddr];
  assign mbit = s.mask[s.idx[6:0]];

  // Memory side advances only when the memory accepts; others run one element a cycle
  assign step = (s.kind == vrs_pkg::OP_LOAD || s.kind == vrs_pkg::OP_STORE) ? mem_ready : 1'b1;

  // ----------------------------------------------------------------
  // Start decode
  // ----------------------------------------------------------------
  // Any operand that takes the offset shortens the run
  assign use_off = destination_operand[4] | first_source_operand[4] | second_source_operand[4];
  assign off_sum = {1'b0, s.first} + s.count;
  // Single-element move wraps within the accumulator
  assign mov_pos = 7'(s.first + scalar_index_operand);

  assign addr_ph = hsel & htrans[1] & hready;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_s    = s;
    next_s.done = 1'b0;
    acc_we    = 1'b0;
    acc_waddr = elem_addr(s.dsel, s.idx[6:0], s.first);
    acc_wdata = 64'h0;

    // Register write lands in the data phase after the address was taken
    if (s.wpend) begin
      unique case (s.wreg)
        vrs_pkg::REG_COUNT: begin
          if (hwdata[31])
            next_s.count = 8'h00;
          else if (hwdata > 32'(vrs_pkg::MAX_COUNT))
            next_s.count = vrs_pkg::MAX_COUNT;
          else
            next_s.count = hwdata[7:0];
        end
        vrs_pkg::REG_STRIDE: next_s.stride = hwdata;
        vrs_pkg::REG_FIRST:  next_s.first  = hwdata[6:0];
        vrs_pkg::REG_STATUS: next_s.stride = s.stride;     // Read only
        default: next_s.mask[32*(s.wreg[1:0]) +: 32] = hwdata;
      endcase
    end
    next_s.wpend = addr_ph & hwrite;
    next_s.wreg  = haddr[4:2];

    // Read data is captured at the address phase and shown in the data phase
    if (addr_ph && !hwrite && haddr[31:5] == 27'h0) begin
      unique case (haddr[4:2])
        vrs_pkg::REG_COUNT:  next_s.rdata = {24'h0, s.count};
        vrs_pkg::REG_STRIDE: next_s.rdata = s.stride;
        vrs_pkg::REG_FIRST:  next_s.rdata = {25'h0, s.first};
        vrs_pkg::REG_STATUS: next_s.rdata = {30'h0, WIDE, s.state == vrs_pkg::ST_RUN};
        default:             next_s.rdata = s.mask[32*(haddr[3:2]) +: 32];
      endcase
    end else if (addr_ph) begin
      next_s.rdata = 32'h0;  // Unmapped reads return zero
    end
    if (addr_ph && haddr[31:5] != 27'h0)
      next_s.wpend = 1'b0;   // Unmapped writes are dropped

    unique case (s.state)
      vrs_pkg::ST_IDLE: begin
        if (op_start) begin
          next_s.kind   = op_kind;
          next_s.size   = op_size;
          next_s.cmp    = op_cmp;
          next_s.masked = op_masked & WIDE;
          next_s.dsel   = destination_operand;
          next_s.s1sel  = first_source_operand;
          next_s.s2sel  = second_source_operand;
          next_s.scalar = op_scalar;
          next_s.addr   = op_base;
          next_s.idx    = 8'h00;
          next_s.widx   = 7'h00;
          if (use_off && off_sum > vrs_pkg::MAX_COUNT)
            next_s.lim = vrs_pkg::MAX_COUNT - {1'b0, s.first};
          else
            next_s.lim = s.count;
          if (s.count == 8'h00) begin
            next_s.done = 1'b1;
          end else if (op_kind == vrs_pkg::OP_TO_ELEM) begin
            acc_waddr   = {elem_addr(destination_operand, 7'h00, 7'h00)} | {4'h0, mov_pos};
            acc_we      = 1'b1;
            acc_wdata   = merge_width(rd_d, op_scalar, op_size);
            next_s.done = 1'b1;
          end else if (op_kind == vrs_pkg::OP_TO_SCALAR) begin
            acc_waddr     = {elem_addr(first_source_operand, 7'h00, 7'h00)} | {4'h0, mov_pos};
            next_s.result = merge_width(64'h0, rd_d, op_size);
            next_s.done   = 1'b1;
          end else begin
            next_s.state = vrs_pkg::ST_RUN;
          end
        end
      end
      vrs_pkg::ST_RUN: begin
        if (step) begin
          unique case (s.kind)
            vrs_pkg::OP_COPY: begin
              acc_we    = !s.masked || mbit;
              acc_wdata = merge_width(rd_d, rd_a, s.size);
            end
            vrs_pkg::OP_MERGE: begin
              acc_we    = 1'b1;
              acc_wdata = merge_width(rd_d, mbit ? rd_a : rd_b, s.size);
            end
            vrs_pkg::OP_FILL: begin
              acc_we    = !s.masked || mbit;
              acc_wdata = merge_width(rd_d, s.scalar, s.size);
            end
            vrs_pkg::OP_CMP: begin
              next_s.mask[s.idx[6:0]] = compare(rd_a, rd_b, s.cmp);
            end
            vrs_pkg::OP_LOAD: begin
              acc_we    = 1'b1;
              acc_wdata = merge_width(rd_d, mem_rdata, s.size);
            end
            vrs_pkg::OP_COMPRESS: begin
              // Selected elements pack down from position zero
              acc_waddr = elem_addr(s.dsel, s.widx, s.first);
              acc_we    = mbit;
              acc_wdata = merge_width(rd_d, rd_a, s.size);
              if (mbit)
                next_s.widx = s.widx + 7'h01;
            end
            vrs_pkg::OP_EXPAND: begin
              acc_we    = mbit;
              acc_wdata = merge_width(rd_d, rd_a, s.size);
              if (mbit)
                next_s.widx = s.widx + 7'h01;
            end
            default: acc_we = 1'b0;  // Stores write no element
          endcase
          // Stride is signed, so a negative one walks downward; zero repeats
          next_s.addr = s.addr + s.stride;
          next_s.idx  = s.idx + 8'h01;
          if (s.idx + 8'h01 >= s.lim) begin
            next_s.state = vrs_pkg::ST_IDLE;
            next_s.done  = 1'b1;
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s        <= '0;
      s.state  <= vrs_pkg::ST_IDLE;
      s.count  <= vrs_pkg::RST_COUNT;
      s.stride <= vrs_pkg::RST_STRIDE;
      s.first  <= vrs_pkg::RST_FIRST;
      s.mask   <= vrs_pkg::RST_MASK;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Accumulator write port
  // ----------------------------------------------------------------
  // No reset: contents are undefined until software fills them
  always_ff @(posedge hclk) begin
    if (acc_we)
      acc_mem[acc_waddr] <= acc_wdata;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hreadyout = 1'b1;  // Zero wait states
  assign hresp     = 1'b0;  // Always OKAY
  assign hrdata    = s.rdata;
  assign op_ready  = (s.state == vrs_pkg::ST_IDLE);
  assign op_done   = s.done;
  assign op_result = s.result;
  // Store data comes straight from the array read port
  assign mem_req   = (s.state == vrs_pkg::ST_RUN) &&
                     (s.kind == vrs_pkg::OP_LOAD || s.kind == vrs_pkg::OP_STORE);
  assign mem_we    = mem_req && (s.kind == vrs_pkg::OP_STORE);
  assign mem_addr  = s.addr;
  assign mem_wdata = rd_a;
  assign mem_size  = s.size;

endmodule

// File: tb/vrs_assertions.sv
// Port-level checker for the vector register set
`timescale 1ns/1ns
module vrs_checker (
  input wire logic             hclk,
  input wire logic             hresetn,
  input wire logic             hsel,
  input wire logic [31:0]      haddr,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic [31:0]      hwdata,
  input wire logic             hready,
  input wire logic [31:0]      hrdata,
  input wire logic             op_start,
  input wire logic             op_ready,
  input wire vrs_pkg::vrs_op_e op_kind,
  input wire logic [31:0]      op_base,
  input wire logic             op_done,
  input wire logic             mem_req,
  input wire logic             mem_ready,
  input wire logic [31:0]      mem_addr
);
  // ----------------------------------------------------------------
  // Shadow of count and stride, rebuilt from bus writes
  // ----------------------------------------------------------------
  logic        wph;
  logic [31:0] aph;
  logic [7:0]  cnt_m;
  logic [31:0] stride_m;
  logic        take;
  assign take = hsel && htrans[1] && hready;
  // Writes land at the end of the data phase, so the address is kept one cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wph      <= 1'b0;
      aph      <= 32'h0;
      cnt_m    <= 8'h00;
      stride_m <= 32'h0;
    end else begin
      wph <= take && hwrite;
      aph <= haddr;
      if (wph && aph == 32'h4) stride_m <= hwdata;
      if (wph && aph == 32'h0) cnt_m <= $signed(hwdata) < 0 ? 8'h00 : (hwdata > 32'h80 ? 8'h80 : hwdata[7:0]);
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  zero_count_a: assert property (op_start && op_ready && cnt_m == 8'h00 |=> op_done && !mem_req)
    else $error("operation with zero count did something");
  req_busy_a: assert property (mem_req |-> !op_ready)
    else $error("memory request while idle");
  first_addr_a: assert property (op_start && op_ready && cnt_m != 8'h00 &&
    (op_kind == vrs_pkg::OP_LOAD || op_kind == vrs_pkg::OP_STORE) |=> mem_req && mem_addr == $past(op_base))
    else $error("element zero not at base");
  stride_step_a: assert property (mem_req && mem_ready ##1 mem_req |-> mem_addr == $past(mem_addr) + stride_m)
    else $error("address step differs from stride");
  count_range_a: assert property (take && !hwrite && haddr == 32'h0 |=> hrdata <= 32'h80)
    else $error("count read above limit");
  unmapped_zero_a: assert property (take && !hwrite && haddr >= 32'h20 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  hold_data_a: assert property (!take |=> $stable(hrdata))
    else $error("read data moved without address phase");
  done_pulse_a: assert property (op_done |=> !op_done)
    else $error("done longer than one cycle");
  done_bound_a: assert property (op_start && op_ready |-> ##[1:600] op_done)
    else $error("operation never finished");
  // Main scenarios reached
  cover property (op_start && op_ready && op_kind == vrs_pkg::OP_CMP);
  cover property (mem_req && mem_ready ##1 mem_req);
  cover property (op_start && op_ready && cnt_m == 8'h00);
endmodule

bind vrs_vector_register_set vrs_checker i_vrs_checker (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .op_start(op_start), .op_ready(op_ready),
  .op_kind(op_kind), .op_base(op_base), .op_done(op_done), .mem_req(mem_req), .mem_ready(mem_ready),
  .mem_addr(mem_addr)
);

// File: tb/vrs_testbench.sv
// Self-checking testbench for the vector register set
`timescale 1ns/1ns
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_fail++; $display("Error %0t: got %h expected %h", $time, (a), (e)); end end
module testbench;
  logic               hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, op_start = 0, mem_ready = 0;
  logic [31:0]        haddr = '0, hwdata = '0, op_base = 32'h1000, rd;
  logic [1:0]         htrans = '0;
  logic [4:0]         sel = '0;
  logic [6:0]         sidx = '0;
  logic [63:0]        op_scalar = '0, mem_rdata = '0;
  vrs_pkg::vrs_op_e   op_kind = vrs_pkg::OP_COPY;
  vrs_pkg::vrs_size_e op_size = vrs_pkg::SZ_LONG;
  vrs_pkg::vrs_cmp_e  op_cmp = vrs_pkg::CMP_EQ;
  wire                hready, hreadyout, hresp, op_ready, op_done, mem_req, mem_we;
  wire [31:0]         hrdata, mem_addr;
  wire [63:0]         op_result, mem_wdata;
  vrs_pkg::vrs_size_e mem_size;
  logic [31:0]        addrs[$];
  int                 n_fail = 0, num_checks = 0, lat = 0;
  assign hready = hreadyout;
  vrs_vector_register_set i_vrs_vector_register_set (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .op_start(op_start), .op_ready(op_ready), .op_kind(op_kind), .op_size(op_size), .op_cmp(op_cmp),
    .op_masked(1'b0), .destination_operand(sel), .first_source_operand(sel), .second_source_operand(sel),
    .scalar_index_operand(sidx), .op_scalar(op_scalar), .op_base(op_base), .op_done(op_done),
    .op_result(op_result), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_size(mem_size), .mem_ready(mem_ready), .mem_rdata(mem_rdata));
  always #25 hclk = ~hclk;
  // Slow memory: every element waits one idle cycle, accepted addresses are logged
  always @(posedge hclk) begin
    mem_ready <= mem_req && !mem_ready;
    mem_rdata <= {32'h0, mem_addr};
    if (mem_req && mem_ready) addrs.push_back(mem_addr);
  end
  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
    @(posedge hclk); while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    @(posedge hclk); while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  // Done is a registered pulse, so it is sampled at the edge that closes its cycle
  task automatic op(input vrs_pkg::vrs_op_e k, input logic [4:0] s, input vrs_pkg::vrs_size_e z,
                    input logic [6:0] x, input logic [63:0] v);
    addrs.delete(); lat = 0;
    op_kind <= k; sel <= s; op_size <= z; sidx <= x; op_scalar <= v; op_start <= 1'b1;
    @(posedge hclk); op_start <= 1'b0;
    do begin @(posedge hclk); lat++; end while (op_done !== 1'b1 && lat < 600);
    `CHK(op_done, 1'b1)
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    for (int i = 0; i < 9; i++) begin bus(0, 32'(i * 4), 0); `CHK(rd, (i == 3) ? 32'h2 : 32'h0) end
    bus(1, 32'hc, 32'h0); bus(0, 32'hc, 0); `CHK(rd, 32'h2)
    `CHK(hresp, 1'b0)
    `CHK(op_ready, 1'b1)
  endtask
  task automatic t_count;
    logic [31:0] w[6] = '{32'hc8, 32'hfffffffb, 32'h80, 32'h81, 32'h80000000, 32'h5};
    logic [31:0] e[6] = '{32'h80, 32'h0, 32'h80, 32'h80, 32'h0, 32'h5};
    for (int i = 0; i < 6; i++) begin bus(1, 0, w[i]); bus(0, 0, 0); `CHK(rd, e[i]) end
  endtask
  task automatic t_stride;
    logic [31:0] s[3] = '{32'h8, 32'hfffffff8, 32'h0};
    bus(1, 0, 32'h3);
    for (int i = 0; i < 3; i++) begin
      bus(1, 4, s[i]); op(vrs_pkg::OP_LOAD, 5'h01, vrs_pkg::SZ_LONG, 0, 0);
      `CHK(addrs.size(), 3)
      for (int j = 0; j < 3; j++) `CHK(addrs[j], 32'(32'h1000 + j * s[i]))
    end
  endtask
  task automatic t_cmp;
    bus(1, 0, 32'h80); op(vrs_pkg::OP_FILL, 5'h02, vrs_pkg::SZ_LONG, 0, 64'h7);
    bus(1, 0, 32'h3); bus(1, 32'h10, 32'hffffffff); op_cmp <= vrs_pkg::CMP_NE;
    op(vrs_pkg::OP_CMP, 5'h02, vrs_pkg::SZ_LONG, 0, 0); bus(0, 32'h10, 0); `CHK(rd, 32'hfffffff8)
    op_cmp <= vrs_pkg::CMP_EQ;
    op(vrs_pkg::OP_CMP, 5'h02, vrs_pkg::SZ_LONG, 0, 0); bus(0, 32'h10, 0); `CHK(rd, 32'hffffffff)
    bus(1, 0, 32'h0); op_cmp <= vrs_pkg::CMP_NE;
    op(vrs_pkg::OP_CMP, 5'h02, vrs_pkg::SZ_LONG, 0, 0); `CHK(lat, 1)
    bus(0, 32'h10, 0); `CHK(rd, 32'hffffffff)
    op(vrs_pkg::OP_STORE, 5'h02, vrs_pkg::SZ_LONG, 0, 0); `CHK(addrs.size(), 0)
  endtask
  task automatic t_first;
    bus(1, 8, 32'hff); bus(0, 8, 0); `CHK(rd, 32'h7f)
    // Stride of one long word keeps stores clear of overlap; shared operands only feed stores and compares
    bus(1, 0, 32'h5); bus(1, 4, 32'h8);
    op(vrs_pkg::OP_STORE, 5'h12, vrs_pkg::SZ_LONG, 0, 0); `CHK(addrs.size(), 1)
    op(vrs_pkg::OP_STORE, 5'h02, vrs_pkg::SZ_LONG, 0, 0); `CHK(addrs.size(), 5)
    bus(1, 8, 32'h7e); bus(1, 32'h10, 32'hffffffff); bus(1, 32'h1c, 32'hffffffff);
    op(vrs_pkg::OP_CMP, 5'h12, vrs_pkg::SZ_LONG, 0, 0); bus(0, 32'h10, 0); `CHK(rd, 32'hfffffffc)
    bus(0, 32'h1c, 0); `CHK(rd, 32'hffffffff)
  endtask
  task automatic t_move;
    bus(1, 8, 32'h7f); op(vrs_pkg::OP_TO_ELEM, 5'h03, vrs_pkg::SZ_LONG, 4, 64'h1111111111111111);
    bus(1, 8, 32'h0); op(vrs_pkg::OP_TO_SCALAR, 5'h03, vrs_pkg::SZ_LONG, 3, 0);
    `CHK(op_result, 64'h1111111111111111)
    op(vrs_pkg::OP_TO_ELEM, 5'h03, vrs_pkg::SZ_BYTE, 3, 64'haa);
    op(vrs_pkg::OP_TO_SCALAR, 5'h03, vrs_pkg::SZ_LONG, 3, 0); `CHK(op_result, 64'h11111111111111aa)
  endtask
  // ----------------------------------------------------------------
  // Sequence, verdict and watchdog
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs; t_count; t_stride; t_cmp; t_first; t_move;
    finish_test;
  end
  // The whole run needs a few hundred cycles; this limit only catches a hang
  initial begin
    #(50 * 20000);
    n_fail++;
    finish_test;
  end
endmodule
